// File: core/hsc_pkg.sv
`default_nettype none
package hsc_pkg;
	// byte offsets of the configuration space
	localparam logic [7:0] MAKER_LEN_OFS   = 8'h13;
	localparam logic [7:0] PRODUCT_LEN_OFS = 8'h14;
	localparam logic [7:0] SERIAL_LEN_OFS  = 8'h15;
	localparam logic [7:0] MAKER_AREA_LO   = 8'h16;
	localparam logic [7:0] MAKER_AREA_HI   = 8'h53;
	localparam logic [7:0] PRODUCT_AREA_LO = 8'h54;
	localparam logic [7:0] PRODUCT_AREA_HI = 8'h91;
	localparam logic [7:0] SERIAL_AREA_LO  = 8'h92;
	localparam logic [7:0] SERIAL_AREA_HI  = 8'hCF;
	localparam logic [7:0] CHARGE_EN_OFS   = 8'hD0;
	// text limits
	localparam logic [7:0] MAX_CHARS       = 8'h1F;
	localparam int         AREA_BYTES      = 62;
	localparam int         STORE_DEPTH     = 186;
	localparam int         STORE_AW        = 8;
	// charge enable layout: ports 1..4 at bits 1..4
	localparam logic [7:0] CHARGE_EN_MASK  = 8'h1E;
	localparam int         CHARGE_LSB      = 1;
	localparam int         PORT_COUNT      = 4;
	// values after reset
	localparam logic [7:0] LEN_RESET       = 8'h00;
	localparam logic [7:0] CHARGE_RESET    = 8'h00;
	localparam logic [7:0] UNMAPPED_DATA   = 8'h00;
	// text selector for the descriptor fetch port
	typedef enum logic [1:0]
	{
		TXT_MAKER   = 2'b00,
		TXT_PRODUCT = 2'b01,
		TXT_SERIAL  = 2'b10
	} hsc_text_t;
	// descriptor fetch states
	typedef enum logic [1:0]
	{
		FS_IDLE = 2'b00,
		FS_LOW  = 2'b01,
		FS_HIGH = 2'b10,
		FS_DONE = 2'b11
	} hsc_fetch_t;
endpackage : hsc_pkg
`default_nettype wire

// File: core/hsc_text_store.sv
`default_nettype none
// byte store for the three text areas, registered read data
module hsc_text_store
	import hsc_pkg::*;
(
	input  wire logic                   i_clk,
	input  wire logic                   i_wr_en,
	input  wire logic [STORE_AW-1:0]    i_wr_addr,
	input  wire logic [7:0]             i_wr_data,
	input  wire logic [STORE_AW-1:0]    i_rd_addr,
	output var  logic [7:0]             o_rd_data
);
	logic [7:0] mem [STORE_DEPTH];

	// no reset on the array: contents come only from the configuring party
	always_ff @(posedge i_clk)
	begin
		if (i_wr_en)
			mem[i_wr_addr] <= i_wr_data;
	end

	always_ff @(posedge i_clk)
	begin
		o_rd_data <= mem[i_rd_addr];
	end
endmodule : hsc_text_store
`default_nettype wire

// File: core/hsc_config_bank.sv
`default_nettype none
module hsc_config_bank
	import hsc_pkg::*;
(
	input  wire logic                    I_REF_CLK,
	input  wire logic                    I_RST_N,
	input  wire logic                    I_CFG_WR,
	input  wire logic                    I_CFG_RD,
	input  wire logic [7:0]              I_CFG_ADDR,
	input  wire logic [7:0]              I_CFG_WDATA,
	output var  logic [7:0]              O_CFG_RDATA,
	output var  logic                    O_CFG_RVALID,
	input  wire logic                    I_FETCH_START,
	input  wire hsc_pkg::hsc_text_t      I_FETCH_SEL,
	output var  logic [15:0]             O_FETCH_CHAR,
	output var  logic                    O_FETCH_VALID,
	output var  logic                    O_FETCH_DONE,
	output var  logic                    O_FETCH_BUSY,
	output var  logic [PORT_COUNT-1:0]   O_PORT_CHARGE_EN
);
	import hsc_pkg::*;

	logic [7:0]          maker_text_length;
	logic [7:0]          product_text_length;
	logic [7:0]          serial_text_length;
	logic [7:0]          port_charge_enable;
	logic                in_text;
	logic [STORE_AW-1:0] cfg_index;
	logic [STORE_AW-1:0] fetch_index;
	logic [STORE_AW-1:0] store_rd_addr;
	logic [7:0]          store_rd_data;
	logic                rd_from_store;
	logic                rd_pending;
	logic [7:0]          rd_reg_data;
	hsc_fetch_t          fetch_state;
	logic [7:0]          fetch_base;
	logic [7:0]          fetch_len;
	logic [7:0]          char_count;
	logic [7:0]          low_byte;

	// text areas are adjacent, so one offset from 16h covers all three
	always_comb
	begin
		in_text   = (I_CFG_ADDR >= MAKER_AREA_LO) && (I_CFG_ADDR <= SERIAL_AREA_HI);
		cfg_index = I_CFG_ADDR - MAKER_AREA_LO;
	end

	// cfg text read shares the store port; fetch only uses it when no cfg text read
	always_comb
	begin
		if (I_CFG_RD && in_text)
			store_rd_addr = cfg_index;
		else
			store_rd_addr = fetch_index;
	end

	hsc_text_store u_store
	(
		.i_clk     (I_REF_CLK),
		.i_wr_en   (I_CFG_WR && in_text),
		.i_wr_addr (cfg_index),
		.i_wr_data (I_CFG_WDATA),
		.i_rd_addr (store_rd_addr),
		.o_rd_data (store_rd_data)
	);

	// length registers
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			maker_text_length   <= LEN_RESET;
			product_text_length <= LEN_RESET;
			serial_text_length  <= LEN_RESET;
		end
		else if (I_CFG_WR)
		begin
			if (I_CFG_ADDR == MAKER_LEN_OFS)
				maker_text_length <= I_CFG_WDATA;
			else if (I_CFG_ADDR == PRODUCT_LEN_OFS)
				product_text_length <= I_CFG_WDATA;
			else if (I_CFG_ADDR == SERIAL_LEN_OFS)
				serial_text_length <= I_CFG_WDATA;
		end
	end

	// charge enable; reserved bits never store so they read as zero
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			port_charge_enable <= CHARGE_RESET;
		else if (I_CFG_WR && I_CFG_ADDR == CHARGE_EN_OFS)
			port_charge_enable <= I_CFG_WDATA & CHARGE_EN_MASK;
	end

	// per-port enables, registered straight to the pins
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			O_PORT_CHARGE_EN <= '0;
		else
			O_PORT_CHARGE_EN <= port_charge_enable[CHARGE_LSB +: PORT_COUNT];
	end

	// register read mux; unmapped offsets return zero
	always_comb
	begin
		if (I_CFG_ADDR == MAKER_LEN_OFS)
			rd_reg_data = maker_text_length;
		else if (I_CFG_ADDR == PRODUCT_LEN_OFS)
			rd_reg_data = product_text_length;
		else if (I_CFG_ADDR == SERIAL_LEN_OFS)
			rd_reg_data = serial_text_length;
		else if (I_CFG_ADDR == CHARGE_EN_OFS)
			rd_reg_data = port_charge_enable;
		else
			rd_reg_data = UNMAPPED_DATA;
	end

	// answer two cycles after the strobe: the store settles, then the pin flop
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			rd_from_store <= 1'b0;
			rd_pending    <= 1'b0;
			O_CFG_RVALID  <= 1'b0;
		end
		else
		begin
			rd_from_store <= I_CFG_RD && in_text;
			rd_pending    <= I_CFG_RD;
			O_CFG_RVALID  <= rd_pending;
		end
	end

	logic [7:0] reg_hold;
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			reg_hold <= UNMAPPED_DATA;
		else if (I_CFG_RD)
			reg_hold <= rd_reg_data;
	end

	// read data pin from a flop; costs a cycle but no mux drives the pin
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			O_CFG_RDATA <= UNMAPPED_DATA;
		else if (rd_pending)
			O_CFG_RDATA <= rd_from_store ? store_rd_data : reg_hold;
	end

	// fetch base and clamped length for the selected text
	logic [7:0] sel_base;
	logic [7:0] sel_len;
	logic [7:0] sel_raw;
	always_comb
	begin
		case (I_FETCH_SEL)
			TXT_PRODUCT:
			begin
				sel_base = PRODUCT_AREA_LO - MAKER_AREA_LO;
				sel_raw  = product_text_length;
			end
			TXT_SERIAL:
			begin
				sel_base = SERIAL_AREA_LO - MAKER_AREA_LO;
				sel_raw  = serial_text_length;
			end
			default:
			begin
				sel_base = 8'h00;
				sel_raw  = maker_text_length;
			end
		endcase
		// lengths above the supported maximum are clipped, never overrun a neighbour
		sel_len = (sel_raw > MAX_CHARS) ? MAX_CHARS : sel_raw;
	end

	// descriptor fetch: reads low then high byte per character
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			fetch_state   <= FS_IDLE;
			fetch_base    <= 8'h00;
			fetch_len     <= 8'h00;
			char_count    <= 8'h00;
			fetch_index   <= '0;
			low_byte      <= 8'h00;
			O_FETCH_CHAR  <= 16'h0000;
			O_FETCH_VALID <= 1'b0;
			O_FETCH_DONE  <= 1'b0;
			O_FETCH_BUSY  <= 1'b0;
		end
		else
		begin
			O_FETCH_VALID <= 1'b0;
			O_FETCH_DONE  <= 1'b0;
			case (fetch_state)
				FS_IDLE:
				begin
					if (I_FETCH_START)
					begin
						fetch_base   <= sel_base;
						fetch_len    <= sel_len;
						char_count   <= 8'h00;
						fetch_index  <= sel_base;
						O_FETCH_BUSY <= 1'b1;
						fetch_state  <= (sel_len == 8'h00) ? FS_DONE : FS_LOW;
					end
				end
				FS_LOW:
				begin
					// a cfg text read steals the port; retry the same byte next cycle
					if (!(I_CFG_RD && in_text))
					begin
						fetch_index <= fetch_index + 8'h01;
						fetch_state <= FS_HIGH;
					end
				end
				FS_HIGH:
				begin
					if (I_CFG_RD && in_text)
					begin
						// the high byte read is lost to the cfg read, so fetch the character again from its low byte
						fetch_index <= fetch_index - 8'h01;
						fetch_state <= FS_LOW;
					end
					else
					begin
						low_byte    <= store_rd_data;
						fetch_index <= fetch_index + 8'h01;
						fetch_state <= FS_DONE;
					end
				end
				FS_DONE:
				begin
					if (O_FETCH_BUSY && fetch_index != fetch_base)
					begin
						// high byte at the next address pairs with the low byte
						O_FETCH_CHAR  <= {store_rd_data, low_byte};
						O_FETCH_VALID <= 1'b1;
						char_count    <= char_count + 8'h01;
					end
					if (fetch_index == fetch_base || char_count + 8'h01 >= fetch_len)
					begin
						O_FETCH_DONE <= 1'b1;
						O_FETCH_BUSY <= 1'b0;
						fetch_state  <= FS_IDLE;
					end
					else
						fetch_state <= FS_LOW;
				end
				default: fetch_state <= FS_IDLE;
			endcase
		end
	end

	// checks
	chk_len_write: assert property (
		@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CFG_WR && I_CFG_ADDR == PRODUCT_LEN_OFS
		|=> product_text_length == $past(I_CFG_WDATA))
		else $error("product length not stored");
	chk_serial_len: assert property (
		@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CFG_WR && I_CFG_ADDR == SERIAL_LEN_OFS
		|=> serial_text_length == $past(I_CFG_WDATA))
		else $error("serial length not stored");
	chk_maker_len: assert property (
		@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CFG_WR && I_CFG_ADDR == MAKER_LEN_OFS
		|=> maker_text_length == $past(I_CFG_WDATA))
		else $error("maker length not stored");
	chk_text_read: assert property (
		@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CFG_WR && in_text ##1 !I_CFG_WR ##1 I_CFG_RD && I_CFG_ADDR == $past(I_CFG_ADDR, 2)
		|-> ##2 O_CFG_RDATA == $past(I_CFG_WDATA, 4))
		else $error("text byte read back wrong");
	chk_rsvd_zero: assert property (
		@(posedge I_REF_CLK) disable iff (!I_RST_N)
		(port_charge_enable & ~CHARGE_EN_MASK) == 8'h00)
		else $error("reserved charge bit set");
	chk_port_pin: assert property (
		@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CFG_WR && I_CFG_ADDR == CHARGE_EN_OFS
		|-> ##2 O_PORT_CHARGE_EN == $past(I_CFG_WDATA[4:1], 2))
		else $error("charge pin not following enable");
	chk_fetch_count: assert property (
		@(posedge I_REF_CLK) disable iff (!I_RST_N)
		O_FETCH_VALID |-> char_count <= fetch_len)
		else $error("fetch ran past length");
	chk_fetch_ends: assert property (
		@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_FETCH_START && fetch_state == FS_IDLE && sel_len == 8'h00
		|-> ##2 O_FETCH_DONE && !O_FETCH_VALID)
		else $error("empty text fetch misbehaved");
	chk_read_answer: assert property (
		@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CFG_RD |-> ##2 O_CFG_RVALID)
		else $error("cfg read not answered");
	chk_steal_retry: assert property (
		@(posedge I_REF_CLK) disable iff (!I_RST_N)
		fetch_state == FS_HIGH && I_CFG_RD && in_text |=> fetch_state == FS_LOW)
		else $error("fetch kept a stolen byte");
endmodule : hsc_config_bank
`default_nettype wire

// File: sim/hsc_cfg_src.sv
`default_nettype none
// configuration source model: eeprom loader or smbus master, one byte per access
module hsc_cfg_src
(
	input  wire logic       i_clk,
	output var  logic       o_wr,
	output var  logic       o_rd,
	output var  logic [7:0] o_addr,
	output var  logic [7:0] o_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] img [256];
	// idle bus at time zero
	initial
	begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	// one byte access; released address and data lines show inverted values so stale data cannot pass
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		#1;
		o_wr = w;
		o_rd = ~w;
		o_addr = a;
		o_wdata = d;
		@(posedge i_clk);
		#1;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
		if (w)
			img[a] = d;
	endtask : bus
	// one character, low byte at the lower address
	task automatic put_char(input logic [7:0] a, input logic [15:0] c);
		bus(1'b1, a, c[7:0]);
		bus(1'b1, a + 8'h01, c[15:8]);
	endtask : put_char
endmodule : hsc_cfg_src
`default_nettype wire

// File: sim/hub_string_and_charge_config_test.sv
`default_nettype none
module hub_string_and_charge_config_test;
	timeunit 1ns;
	timeprecision 1ns;
	import hsc_pkg::*;
	logic        clk, rst_n, wr, rd, start, rvalid, fvalid, fdone, fbusy;
	logic [7:0]  addr, wdata, rdata, v;
	logic [15:0] fchar;
	logic [3:0]  chg;
	logic [31:0] rnd;
	hsc_text_t   sel;
	int          bad_count, n_tests, nval, n;
	logic [7:0]  rq [$];
	logic [15:0] fq [$];
	localparam logic [7:0] LOFS [3] = '{MAKER_LEN_OFS, PRODUCT_LEN_OFS, SERIAL_LEN_OFS};
	localparam logic [7:0] BASE [3] = '{MAKER_AREA_LO, PRODUCT_AREA_LO, SERIAL_AREA_LO};
	localparam logic [7:0] LENS [3] = '{8'h28, 8'h1F, 8'h00};

	hsc_cfg_src i_hsc_cfg_src (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
		.o_wdata(wdata));
	hsc_config_bank i_hsc_config_bank (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_CFG_WR(wr),
		.I_CFG_RD(rd), .I_CFG_ADDR(addr), .I_CFG_WDATA(wdata), .O_CFG_RDATA(rdata),
		.O_CFG_RVALID(rvalid), .I_FETCH_START(start), .I_FETCH_SEL(sel),
		.O_FETCH_CHAR(fchar), .O_FETCH_VALID(fvalid), .O_FETCH_DONE(fdone),
		.O_FETCH_BUSY(fbusy), .O_PORT_CHARGE_EN(chg));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// read request notes its expected byte first
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		i_hsc_cfg_src.bus(1'b0, a, 8'h00);
	endtask : rd_exp

	// free-running clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// watcher: each answer takes the oldest note, checked once settled
	always @(negedge clk)
	begin
		if (rvalid === 1'b1)
		begin
			if (rq.size() > 0)
				chk("cfg read", {8'h00, rdata}, {8'h00, rq.pop_front()});
			else
				chk("cfg read unasked", 16'h0001, 16'h0000);
		end
		if (fvalid === 1'b1)
		begin
			nval++;
			if (fq.size() > 0)
				chk("fetch char", fchar, fq.pop_front());
			else
				chk("fetch char unasked", 16'h0001, 16'h0000);
		end
	end

	// watchdog at 30000 cycles, well beyond the expected run of under 600 cycles
	initial
	begin
		#(40 * 30000);
		bad_count++;
		stop_test();
	end

	initial
	begin
		rst_n = 1'b0;
		start = 1'b0;
		sel = TXT_MAKER;
		rnd = 32'h3EE3;
		repeat (12) @(posedge clk);
		#1;
		rst_n = 1'b1;
		// reset values, then an unmapped place that ignores writes
		for (int i = 0; i < 3; i++)
			rd_exp(LOFS[i], LEN_RESET);
		rd_exp(CHARGE_EN_OFS, CHARGE_RESET);
		i_hsc_cfg_src.bus(1'b1, 8'hE0, 8'hFF);
		rd_exp(8'hE0, UNMAPPED_DATA);
		// charge enables: extremes, then random patterns
		for (int k = 0; k < 6; k++)
		begin
			rnd = lfsr(rnd);
			v = (k == 0) ? 8'hFF : (k == 1) ? 8'h01 : rnd[7:0];
			i_hsc_cfg_src.bus(1'b1, CHARGE_EN_OFS, v);
			// pins follow one cycle after the register takes the write
			repeat (2) @(negedge clk);
			chk("charge pins", {12'h000, chg}, {12'h000, v[4:1]});
			rd_exp(CHARGE_EN_OFS, v & CHARGE_EN_MASK);
		end
		// let the last read answer first, or reset would swallow it
		repeat (4) @(posedge clk);
		#1;
		// reset in mid-run clears the enables
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("charge after reset", {12'h000, chg}, 16'h0000);
		rst_n = 1'b1;
		// texts: lengths above the limit store whole but fetch only the limit
		for (int t = 0; t < 3; t++)
		begin
			n = (LENS[t] > MAX_CHARS) ? int'(MAX_CHARS) : int'(LENS[t]);
			for (int c = 0; c < n; c++)
			begin
				rnd = lfsr(rnd);
				i_hsc_cfg_src.put_char(BASE[t] + 8'(2 * c), rnd[15:0]);
			end
			// last byte read back right after it was written
			if (n > 0)
			begin
				v = i_hsc_cfg_src.img[BASE[t] + 8'(2 * n - 1)];
				rd_exp(BASE[t] + 8'(2 * n - 1), v);
			end
			i_hsc_cfg_src.bus(1'b1, LOFS[t], LENS[t]);
			rd_exp(LOFS[t], LENS[t]);
			for (int c = 0; c < n; c++)
				fq.push_back({i_hsc_cfg_src.img[BASE[t] + 8'(2 * c + 1)],
					i_hsc_cfg_src.img[BASE[t] + 8'(2 * c)]});
			nval = 0;
			@(posedge clk);
			#1;
			sel = hsc_text_t'(t[1:0]);
			start = 1'b1;
			@(posedge clk);
			#1;
			start = 1'b0;
			chk("fetch busy high", {15'h0000, fbusy}, 16'h0001);
			// a text read during the fetch steals the store port mid-character
			if (n > 0)
				rd_exp(BASE[t], i_hsc_cfg_src.img[BASE[t]]);
			for (int w = 0; w < 200 && fdone !== 1'b1; w++)
				@(negedge clk);
			chk("fetch done", {15'h0000, fdone}, 16'h0001);
			@(posedge clk);
			#1;
			chk("fetch count", 16'(nval), 16'(n));
			chk("fetch busy", {15'h0000, fbusy}, 16'h0000);
		end
		// every note must have met its answer
		chk("reads left", 16'(rq.size()), 16'h0000);
		chk("chars left", 16'(fq.size()), 16'h0000);
		stop_test();
	end
endmodule : hub_string_and_charge_config_test
`default_nettype wire
